// ===== rtl/qpd_pkg.sv
package qpd_pkg;
    // pot and slot geometry
    localparam int POTS = 4;
    localparam int SLOTS = 4;
    localparam int TAPS = 256;

    // device type field expected in the address byte; value is arbitrary
    localparam logic [3:0] DEV_TYPE_ID = 4'hA;

    // opcodes in the upper nibble of the instruction byte
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_SLOT = 4'hB;
    localparam logic [3:0] OP_WR_SLOT = 4'hC;
    localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_WIPER_TO_SLOT = 4'hE;
    localparam logic [3:0] OP_ALL_SLOT_TO_WIPER = 4'h1;
    localparam logic [3:0] OP_ALL_WIPER_TO_SLOT = 4'h8;
    localparam logic [3:0] OP_STEP = 4'h2;
    localparam logic [3:0] OP_STATUS = 4'h5;
    localparam logic [3:0] STATUS_LOW_BITS = 4'h1;

    // last bit index of each byte within a frame
    localparam logic [4:0] ADDR_LAST = 5'h07;
    localparam logic [4:0] INSTR_LAST = 5'h0F;
    localparam logic [4:0] DATA_LAST = 5'h17;

    // values after reset, and the wiper step limits
    localparam logic [7:0] WIPER_RESET = 8'h00;
    localparam logic [7:0] SLOT_RESET = 8'h00;
    localparam logic [7:0] WIPER_MAX = 8'hFF;
    localparam logic [7:0] WIPER_MIN = 8'h00;

    // timing: 25 MHz core clock
    localparam int CLK_KHZ = 25000;
    localparam int WIPER_SETTLE_US = 5;
    localparam int WIPER_SETTLE_CYC = (WIPER_SETTLE_US * CLK_KHZ + 999) / 1000;
    localparam int NV_PROGRAM_MS = 5;
    localparam int NV_PROGRAM_CYC = NV_PROGRAM_MS * CLK_KHZ;

    typedef struct packed {
        logic [3:0] type_id;
        logic [1:0] pad;
        logic [1:0] strap;
    } qpd_addr_t;

    typedef struct packed {
        logic [3:0] opcode;
        logic [1:0] slot;
        logic [1:0] pot;
    } qpd_instr_t;

    typedef logic [POTS-1:0][7:0] qpd_wiper_bus_t;
    typedef logic [POTS-1:0][TAPS-1:0] qpd_tap_bus_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_INSTR = 7'b0000100,
        ST_DATA = 7'b0001000,
        ST_STEP = 7'b0010000,
        ST_DONE = 7'b0100000,
        ST_IGNORE = 7'b1000000
    } qpd_state_t;
endpackage : qpd_pkg

// ===== rtl/qpd_sync.sv
`timescale 1ns/1ns
module qpd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // two flops per bit; the first is read only by the second
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            logic meta_r;
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    meta_r <= RESET_VAL[b];
                    sync_out[b] <= RESET_VAL[b];
                end else begin
                    meta_r <= async_in[b];
                    sync_out[b] <= meta_r;
                end
            end
        end
    endgenerate
endmodule : qpd_sync

// ===== rtl/qpd_top.sv
// How it works
// - address byte comes first; its upper nibble is the device type, checked first.
// - command runs only when address bits 1:0 equal the strap inputs.
// - instruction byte is opcode nibble, two slot bits, two pot bits.
// - slot bits pick slot zero to three in binary order.
// - four 8-bit wiper registers, each decoded to one of 256 taps.
// - after reset each wiper register loads slot zero of its pot.
// - four non-volatile slots per pot; a slot change finishes within 5 ms.
// - programming starts when chip select rises after a complete slot-targeted frame, unless earlier programming is still counting down.
// - status read returns write pending, high while programming runs.
// - opcode 1001 reads the wiper byte, 1010 writes it, slot bits zero.
// - write-wiper data byte lands in the wiper of the selected pot.
// - opcode 1011 returns the slot chosen by pot and slot bits.
// - opcode 1100 writes the chosen slot and starts programming.
// - opcode 1101 copies the chosen slot into that pot's wiper.
// - opcode 1110 copies the pot's wiper into its chosen slot.
// - opcode 0001 copies the chosen slot of all pots into their wipers.
// - opcode 1000 copies all wipers into the chosen slot of each pot.
// - opcode 0010 with slot bits zero arms step mode for one wiper.
// - opcode 0101 with low nibble 0001 returns the status byte.
// - reads, writes and status carry a data byte; copies have two bytes.
// - wiper output follows a register change within 5 to 10 us.
// - in step mode each clock moves the wiper up if input high, else down, holding at FF and 00.
`timescale 1ns/1ns
module qpd_top #(
    parameter int NV_PROG_CYCLES = qpd_pkg::NV_PROGRAM_CYC
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic [1:0] strap_address_bits,
    output logic so,
    output logic so_oe,
    output qpd_pkg::qpd_wiper_bus_t wiper_code,
    output qpd_pkg::qpd_tap_bus_t tap_select,
    output logic write_pending_flag
);
    import qpd_pkg::*;

    logic cs_n_s, sck_s, si_s;
    logic [1:0] strap_s;
    logic cs_n_d_r, sck_d_r;
    logic sck_rise, sck_fall, cs_rise;
    qpd_state_t state_r;
    logic [4:0] bit_cnt_r;
    logic [7:0] rx_r, rx_nxt;
    qpd_instr_t instr_r, instr_nxt;
    qpd_addr_t addr_nxt;
    logic [7:0] tx_r;
    logic so_r, so_oe_r;
    logic boot_pend_r;
    qpd_wiper_bus_t wpr_r;
    logic [7:0] slot_mem_r [POTS][SLOTS];
    logic [7:0] wr_byte_r;
    qpd_wiper_bus_t nv_stage_r;
    logic [POTS-1:0] nv_mask_r;
    logic [1:0] nv_slot_r;
    logic [31:0] nv_cnt_r;
    logic write_pending_r;
    logic nv_done, commit, commit_ok;
    logic addr_hit, instr_hit, data_hit, step_hit;
    qpd_wiper_bus_t wiper_code_r;
    qpd_tap_bus_t tap_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // pins cross into the core clock; chip select idles high
    qpd_sync #(.WIDTH(5), .RESET_VAL(5'h10)) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in({cs_n, sck, si, strap_address_bits}),
        .sync_out({cs_n_s, sck_s, si_s, strap_s})
    );

    // edge finders on the synchronised link clock and chip select
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cs_n_d_r <= 1'b1;
            sck_d_r <= 1'b0;
        end else begin
            cs_n_d_r <= cs_n_s;
            sck_d_r <= sck_s;
        end
    end

    assign sck_rise = sck_s & ~sck_d_r;
    assign sck_fall = ~sck_s & sck_d_r;
    assign cs_rise = cs_n_s & ~cs_n_d_r;
    assign rx_nxt = {rx_r[6:0], si_s};
    assign addr_nxt = qpd_addr_t'(rx_nxt);
    assign instr_nxt = qpd_instr_t'(rx_nxt);

    // fixed fields of each opcode must match, anything else is undefined
    function automatic logic instr_valid(input qpd_instr_t i);
        case (i.opcode)
            OP_RD_WIPER, OP_WR_WIPER, OP_STEP: instr_valid = (i.slot == 2'h0);
            OP_RD_SLOT, OP_WR_SLOT, OP_SLOT_TO_WIPER, OP_WIPER_TO_SLOT: instr_valid = 1'b1;
            OP_ALL_SLOT_TO_WIPER, OP_ALL_WIPER_TO_SLOT: instr_valid = (i.pot == 2'h0);
            OP_STATUS: instr_valid = ({i.slot, i.pot} == STATUS_LOW_BITS);
            default: instr_valid = 1'b0;
        endcase
    endfunction : instr_valid

    function automatic logic has_data(input logic [3:0] op);
        has_data = (op == OP_RD_WIPER) || (op == OP_WR_WIPER) || (op == OP_RD_SLOT) ||
                   (op == OP_WR_SLOT) || (op == OP_STATUS);
    endfunction : has_data

    function automatic logic is_read(input logic [3:0] op);
        is_read = (op == OP_RD_WIPER) || (op == OP_RD_SLOT) || (op == OP_STATUS);
    endfunction : is_read

    function automatic logic to_slot(input logic [3:0] op);
        to_slot = (op == OP_WR_SLOT) || (op == OP_WIPER_TO_SLOT) || (op == OP_ALL_WIPER_TO_SLOT);
    endfunction : to_slot

    // byte boundary events, and every link clock rise in step mode
    assign addr_hit = sck_rise && (state_r == ST_ADDR) && (bit_cnt_r == ADDR_LAST);
    assign instr_hit = sck_rise && (state_r == ST_INSTR) && (bit_cnt_r == INSTR_LAST) &&
                       instr_valid(instr_nxt);
    assign data_hit = sck_rise && (state_r == ST_DATA) && (bit_cnt_r == DATA_LAST);
    assign step_hit = sck_rise && (state_r == ST_STEP);

    // frame sequencer; deselect always returns to idle, aborting a partial frame
    always_ff @(posedge core_clk) begin
        if (srst || cs_n_s) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 5'h00;
            rx_r <= 8'h00;
            instr_r <= '0;
        end else if (state_r == ST_IDLE) begin
            state_r <= ST_ADDR;
        end else if (sck_rise) begin
            rx_r <= rx_nxt;
            if (bit_cnt_r != DATA_LAST) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
            case (state_r)
                ST_ADDR: begin
                    if (bit_cnt_r == ADDR_LAST) begin
                        if (addr_nxt.type_id == DEV_TYPE_ID && addr_nxt.strap == strap_s) begin
                            state_r <= ST_INSTR;
                        end else begin
                            state_r <= ST_IGNORE;
                        end
                    end
                end
                ST_INSTR: begin
                    if (bit_cnt_r == INSTR_LAST) begin
                        instr_r <= instr_nxt;
                        if (!instr_valid(instr_nxt)) begin
                            state_r <= ST_IGNORE;
                        end else if (instr_nxt.opcode == OP_STEP) begin
                            state_r <= ST_STEP;
                        end else if (has_data(instr_nxt.opcode)) begin
                            state_r <= ST_DATA;
                        end else begin
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_DATA: begin
                    if (bit_cnt_r == DATA_LAST) begin
                        state_r <= ST_DONE;
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    sequence s_addr_byte;
        sck_rise && state_r == ST_ADDR && bit_cnt_r == ADDR_LAST;
    endsequence

    a_addr_mismatch_ignored: assert property (
        s_addr_byte ##0 (addr_nxt.strap != strap_s) ##1 !cs_n_s |-> state_r == ST_IGNORE)
        else $error("strap mismatch did not ignore frame");

    a_type_mismatch_ignored: assert property (
        s_addr_byte ##0 (addr_nxt.type_id != DEV_TYPE_ID) |=> !(state_r inside {ST_INSTR}))
        else $error("wrong device type accepted");

    // read data: loaded at the instruction boundary, shifted out on falling edges
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_r <= 8'h00;
        end else if (instr_hit) begin
            case (instr_nxt.opcode)
                OP_RD_WIPER: tx_r <= wpr_r[instr_nxt.pot];
                OP_RD_SLOT: tx_r <= slot_mem_r[instr_nxt.pot][instr_nxt.slot];
                OP_STATUS: tx_r <= {7'h00, write_pending_r};
                default: tx_r <= 8'h00;
            endcase
        end else if (sck_fall && state_r == ST_DATA) begin
            tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    // output driven only during the data byte of a read; released otherwise
    always_ff @(posedge core_clk) begin
        if (srst) begin
            so_r <= 1'b0;
            so_oe_r <= 1'b0;
        end else begin
            so_oe_r <= (state_r == ST_DATA) && is_read(instr_r.opcode) && !cs_n_s;
            if (sck_fall && state_r == ST_DATA) begin
                so_r <= tx_r[7];
            end
        end
    end

    a_ignore_releases_so: assert property (
        state_r == ST_IGNORE |=> !so_oe_r)
        else $error("output driven while ignoring a frame");

    a_status_byte: assert property (
        instr_hit && instr_nxt.opcode == OP_STATUS |=> tx_r == {7'h00, $past(write_pending_r)})
        else $error("status byte wrong");

    // wiper registers: boot load, direct write, copies and stepping
    always_ff @(posedge core_clk) begin
        if (srst) begin
            boot_pend_r <= 1'b1;
            wpr_r <= {POTS{WIPER_RESET}};
        end else begin
            boot_pend_r <= 1'b0;
            if (boot_pend_r) begin
                for (int p = 0; p < POTS; p++) begin
                    wpr_r[p] <= slot_mem_r[p][0];
                end
            end else if (instr_hit && instr_nxt.opcode == OP_SLOT_TO_WIPER) begin
                wpr_r[instr_nxt.pot] <= slot_mem_r[instr_nxt.pot][instr_nxt.slot];
            end else if (instr_hit && instr_nxt.opcode == OP_ALL_SLOT_TO_WIPER) begin
                for (int p = 0; p < POTS; p++) begin
                    wpr_r[p] <= slot_mem_r[p][instr_nxt.slot];
                end
            end else if (data_hit && instr_r.opcode == OP_WR_WIPER) begin
                wpr_r[instr_r.pot] <= rx_nxt;
            end else if (step_hit) begin
                // saturate instead of wrapping so a runaway step train parks at an end
                if (si_s && wpr_r[instr_r.pot] != WIPER_MAX) begin
                    wpr_r[instr_r.pot] <= wpr_r[instr_r.pot] + 8'h01;
                end else if (!si_s && wpr_r[instr_r.pot] != WIPER_MIN) begin
                    wpr_r[instr_r.pot] <= wpr_r[instr_r.pot] - 8'h01;
                end
            end
        end
    end

    a_boot_load: assert property (
        boot_pend_r |=> wpr_r[0] == $past(slot_mem_r[0][0]) && wpr_r[3] == $past(slot_mem_r[3][0]))
        else $error("wiper not loaded from slot zero");

    a_wiper_write: assert property (
        data_hit && instr_r.opcode == OP_WR_WIPER |=> wpr_r[$past(instr_r.pot)] == $past(rx_nxt))
        else $error("wiper write lost");

    a_step_up: assert property (
        step_hit && si_s && wpr_r[instr_r.pot] != WIPER_MAX |=>
        wpr_r[instr_r.pot] == $past(wpr_r[instr_r.pot]) + 8'h01)
        else $error("step up wrong");

    a_step_saturate: assert property (
        step_hit && !si_s && wpr_r[instr_r.pot] == WIPER_MIN |=> wpr_r[instr_r.pot] == WIPER_MIN)
        else $error("step wrapped below zero");

    // slot-targeted frames commit only on deselect after a complete frame
    assign nv_done = write_pending_r && (nv_cnt_r == 32'h0);
    assign commit = cs_rise && (state_r == ST_DONE) && to_slot(instr_r.opcode);
    assign commit_ok = commit && (!write_pending_r || nv_done);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_byte_r <= 8'h00;
        end else if (data_hit && instr_r.opcode == OP_WR_SLOT) begin
            wr_byte_r <= rx_nxt;
        end
    end

    // programming timer; a new commit in the finishing cycle wins over the clear
    always_ff @(posedge core_clk) begin
        if (srst) begin
            write_pending_r <= 1'b0;
            nv_cnt_r <= 32'h0;
            nv_stage_r <= '0;
            nv_mask_r <= '0;
            nv_slot_r <= 2'h0;
        end else if (commit_ok) begin
            write_pending_r <= 1'b1;
            nv_cnt_r <= 32'(NV_PROG_CYCLES - 1);
            nv_slot_r <= instr_r.slot;
            for (int p = 0; p < POTS; p++) begin
                nv_stage_r[p] <= (instr_r.opcode == OP_WR_SLOT) ? wr_byte_r : wpr_r[p];
                nv_mask_r[p] <= (instr_r.opcode == OP_ALL_WIPER_TO_SLOT) ||
                                (instr_r.pot == 2'(p));
            end
        end else if (nv_done) begin
            write_pending_r <= 1'b0;
        end else if (write_pending_r) begin
            nv_cnt_r <= nv_cnt_r - 32'h1;
        end
    end

    // slot storage is written only when the programming time has run out
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int p = 0; p < POTS; p++) begin
                for (int s = 0; s < SLOTS; s++) begin
                    slot_mem_r[p][s] <= SLOT_RESET;
                end
            end
        end else if (nv_done) begin
            for (int p = 0; p < POTS; p++) begin
                if (nv_mask_r[p]) begin
                    slot_mem_r[p][nv_slot_r] <= nv_stage_r[p];
                end
            end
        end
    end

    a_commit_pending: assert property (
        commit && !write_pending_r |=> write_pending_r)
        else $error("programming did not start on deselect");

    // helper: age of the current programming cycle
    logic [31:0] pend_age_r;
    always_ff @(posedge core_clk) begin
        if (srst || commit_ok || !write_pending_r) begin
            pend_age_r <= 32'h0;
        end else begin
            pend_age_r <= pend_age_r + 32'h1;
        end
    end

    a_program_bounded: assert property (
        write_pending_r |-> pend_age_r < 32'(NV_PROG_CYCLES))
        else $error("programming exceeded its time");

    // wiper output waits the settle time, then follows the register; decoded one-hot
    genvar g;
    generate
        for (g = 0; g < POTS; g++) begin : g_pot
            logic [7:0] settle_r;
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    settle_r <= 8'h00;
                    wiper_code_r[g] <= WIPER_RESET;
                    tap_r[g] <= {{(TAPS-1){1'b0}}, 1'b1};
                end else begin
                    tap_r[g] <= {{(TAPS-1){1'b0}}, 1'b1} << wiper_code_r[g];
                    if (wiper_code_r[g] == wpr_r[g]) begin
                        settle_r <= 8'h00;
                    end else if (settle_r == 8'(WIPER_SETTLE_CYC - 1)) begin
                        settle_r <= 8'h00;
                        wiper_code_r[g] <= wpr_r[g];
                    end else begin
                        settle_r <= settle_r + 8'h01;
                    end
                end
            end

            a_tap_onehot: assert property (
                ##1 $onehot(tap_r[g]) && tap_r[g][$past(wiper_code_r[g])])
                else $error("tap select not one-hot of wiper code");
        end
    endgenerate

    assign so = so_r;
    assign so_oe = so_oe_r;
    assign wiper_code = wiper_code_r;
    assign tap_select = tap_r;
    assign write_pending_flag = write_pending_r;
endmodule : qpd_top

// ===== tb/qpd_master.sv
`timescale 1ns/1ns
module qpd_master (
    input wire logic core_clk,
    input wire logic so,
    input wire logic so_oe,
    output logic cs_n,
    output logic sck,
    output logic si
);
    logic [7:0] rx_r;
    event got;

    // idle: clock stands still low, chip deselected
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        rx_r = 8'h00;
    end

    // one frame, msb first, sck of 8 core cycles (320 ns); bits past n are not sent
    task automatic frame(input logic [23:0] bits, input int n);
        bit seen;
        seen = 1'b0;
        @(posedge core_clk) cs_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            si <= bits[23 - i];
            repeat (4) @(posedge core_clk);
            sck <= 1'b1;
            repeat (4) @(posedge core_clk);
            // sample late in the high phase; so moves only after the falling edge
            if (i >= 16) begin
                rx_r <= {rx_r[6:0], so_oe ? so : ~so};
            end
            if (i == 16) begin
                seen = so_oe;
            end
            sck <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        cs_n <= 1'b1;
        // released line: toggle si so no stale level can pass for data
        repeat (8) begin
            @(posedge core_clk);
            si <= ~si;
        end
        if (seen) begin
            -> got;
        end
    endtask : frame
endmodule : qpd_master

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    import qpd_pkg::*;
    localparam int NVP = 400;
    logic core_clk, srst, cs_n, sck, si, so, so_oe, write_pending_flag;
    logic [1:0] strap;
    qpd_wiper_bus_t wiper_code;
    qpd_tap_bus_t tap_select;
    logic [7:0] exp_q[$];
    logic [7:0] slot_m [POTS][SLOTS];
    logic [7:0] d;
    int cmp_count, bad_count;

    qpd_top #(.NV_PROG_CYCLES(NVP)) dut (.core_clk(core_clk), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si),
        .strap_address_bits(strap), .so(so), .so_oe(so_oe), .wiper_code(wiper_code),
        .tap_select(tap_select), .write_pending_flag(write_pending_flag));
    qpd_master m (.core_clk(core_clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));

    // 25 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [7:0] ab();
        return {DEV_TYPE_ID, 2'b00, strap};
    endfunction : ab

    task automatic cmd(input logic [7:0] ins, input logic [7:0] dat, input int n);
        m.frame({ab(), ins, dat}, n);
    endtask : cmd

    // read frame: the expected byte is noted before the frame goes out
    task automatic rd(input logic [7:0] ins, input logic [7:0] e);
        exp_q.push_back(e);
        m.frame({ab(), ins, 8'h00}, 24);
    endtask : rd

    // long enough for a full programming cycle plus the sync delay
    task automatic nvwait();
        repeat (NVP + 20) @(posedge core_clk);
    endtask : nvwait

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // monitor: each byte the device returns is matched to the oldest note
    initial begin
        forever begin
            @(m.got);
            if (exp_q.size() == 0) begin
                `CHK(m.rx_r, 8'hXX)
            end else begin
                `CHK(m.rx_r, exp_q.pop_front())
            end
        end
    end

    // watchdog sized well above the expected run of about 29k cycles
    initial begin
        repeat (90000) @(posedge core_clk);
        bad_count++;
        summarize();
    end

    initial begin
        void'($urandom(32'hc80c));
        srst = 1'b1;
        strap = 2'($urandom);
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        repeat (8) @(posedge core_clk);
        // blank part: each wiper starts at the reset value of its slot zero
        for (int p = 0; p < POTS; p++) begin
            rd({OP_RD_WIPER, 2'b00, 2'(p)}, SLOT_RESET);
        end
        // every slot of every pot: write, pending flag, read back
        for (int p = 0; p < POTS; p++) begin
            for (int s = 0; s < SLOTS; s++) begin
                d = 8'($urandom);
                slot_m[p][s] = d;
                rd({OP_RD_SLOT, 2'(s), 2'(p)}, SLOT_RESET);
                cmd({OP_WR_SLOT, 2'(s), 2'(p)}, d, 24);
                `CHK(write_pending_flag, 1'b1)
                rd({OP_STATUS, STATUS_LOW_BITS}, 8'h01);
                nvwait();
                `CHK(write_pending_flag, 1'b0)
                rd({OP_RD_SLOT, 2'(s), 2'(p)}, d);
            end
        end
        rd({OP_STATUS, STATUS_LOW_BITS}, 8'h00);
        // wiper writes reach the tap decoder after settling
        for (int p = 0; p < POTS; p++) begin
            d = 8'($urandom);
            cmd({OP_WR_WIPER, 2'b00, 2'(p)}, d, 24);
            rd({OP_RD_WIPER, 2'b00, 2'(p)}, d);
            repeat (140) @(posedge core_clk);
            `CHK(wiper_code[p], d)
            `CHK(tap_select[p], 256'(1) << d)
        end
        cmd({OP_SLOT_TO_WIPER, 2'd2, 2'd1}, 8'h00, 16);
        rd({OP_RD_WIPER, 2'b00, 2'd1}, slot_m[1][2]);
        cmd({OP_ALL_SLOT_TO_WIPER, 2'd3, 2'b00}, 8'h00, 16);
        for (int p = 0; p < POTS; p++) begin
            rd({OP_RD_WIPER, 2'b00, 2'(p)}, slot_m[p][3]);
        end
        cmd({OP_WIPER_TO_SLOT, 2'd1, 2'd0}, 8'h00, 16);
        nvwait();
        rd({OP_RD_SLOT, 2'd1, 2'd0}, slot_m[0][3]);
        cmd({OP_ALL_WIPER_TO_SLOT, 2'd0, 2'b00}, 8'h00, 16);
        nvwait();
        for (int p = 0; p < POTS; p++) begin
            rd({OP_RD_SLOT, 2'd0, 2'(p)}, slot_m[p][3]);
        end
        // wrong type field, then wrong strap: the write must not land
        m.frame({~DEV_TYPE_ID, 2'b00, strap, OP_WR_WIPER, 4'h0, 8'h3C}, 24);
        m.frame({DEV_TYPE_ID, 2'b00, ~strap, OP_WR_WIPER, 4'h0, 8'h3C}, 24);
        rd({OP_RD_WIPER, 2'b00, 2'd0}, slot_m[0][3]);
        // stepping saturates at both ends
        cmd({OP_WR_WIPER, 2'b00, 2'd2}, 8'hFE, 24);
        cmd({OP_STEP, 2'b00, 2'd2}, 8'hE0, 19);
        rd({OP_RD_WIPER, 2'b00, 2'd2}, WIPER_MAX);
        cmd({OP_WR_WIPER, 2'b00, 2'd2}, 8'h01, 24);
        cmd({OP_STEP, 2'b00, 2'd2}, 8'h00, 19);
        rd({OP_RD_WIPER, 2'b00, 2'd2}, WIPER_MIN);
        repeat (20) @(posedge core_clk);
        `CHK(exp_q.size(), 0)
        summarize();
    end
endmodule : tb_top
